/* src/otx_cfg.svh */
`ifndef OTX_CFG_SVH
`define OTX_CFG_SVH
// channel count of the transceiver
`define OTX_WIDTH       8
// enable low means device drives
`define OTX_EN_ON       1'b0
`define OTX_EN_OFF      1'b1
// flow_select levels
`define OTX_FLOW_R2L    1'b0
`define OTX_FLOW_L2R    1'b1
// clock period in ps and turnaround gap time in ns
`define OTX_CLK_PS      4000
`define OTX_GAP_NS      20
`define OTX_GAP_CYC     ((`OTX_GAP_NS * 1000 + `OTX_CLK_PS - 1) / `OTX_CLK_PS)
`define OTX_CNT_W       4
`endif

/* src/otx_pkg.sv */
package otx_pkg;
    typedef enum logic [2:0] {
        OTX_OFF,
        OTX_SET_DIR,
        OTX_ON,
        OTX_GAP
    } otx_state_t;
endpackage

/* src/otx_lane.sv */
`timescale 1ns/1ps
`include "otx_cfg.svh"
// one channel pair on the host side: drives a side only while device floats it
module otx_lane (
    input  wire logic drv_left,
    input  wire logic drv_right,
    input  wire logic left_val,
    input  wire logic right_val,
    input  wire logic left_in,
    input  wire logic right_in,
    output logic      left_out,
    output logic      left_oe_n,
    output logic      right_out,
    output logic      right_oe_n,
    output logic      left_seen,
    output logic      right_seen
);
    assign left_out   = left_val;
    assign right_out  = right_val;
    assign left_oe_n  = ~drv_left;
    assign right_oe_n = ~drv_right;
    assign left_seen  = left_in;
    assign right_seen = right_in;
endmodule

/* src/otx_host.sv */
`timescale 1ns/1ps
`include "otx_cfg.svh"
module otx_host (
    input  wire logic                   clk,
    input  wire logic                   rst_b,
    input  wire logic                   req_valid,
    input  wire logic                   req_flow,
    input  wire logic                   req_off,
    output logic                        req_ready,
    input  wire logic [`OTX_WIDTH-1:0]  tx_data,
    output logic [`OTX_WIDTH-1:0]       rx_data,
    output logic                        link_on,
    output logic                        flow_select,
    output logic                        drive_enable_n,
    input  wire logic [`OTX_WIDTH-1:0]  left_port_bit_in,
    output logic [`OTX_WIDTH-1:0]       left_port_bit_out,
    output logic [`OTX_WIDTH-1:0]       left_port_bit_oe_n,
    input  wire logic [`OTX_WIDTH-1:0]  right_port_bit_in,
    output logic [`OTX_WIDTH-1:0]       right_port_bit_out,
    output logic [`OTX_WIDTH-1:0]       right_port_bit_oe_n
);
    otx_pkg::otx_state_t state_ff, nxt_state;
    logic                     flow_ff, nxt_flow;
    logic                     en_n_ff, nxt_en_n;
    logic                     want_ff, nxt_want;
    logic [`OTX_CNT_W-1:0]    cnt_ff, nxt_cnt;
    logic [`OTX_WIDTH-1:0]    tx_ff, nxt_tx;
    logic [`OTX_WIDTH-1:0]    rx_ff, nxt_rx;
    logic                     drv_l, drv_r;
    logic [`OTX_WIDTH-1:0]    l_seen, r_seen;

    // host drives the side the device reads; driving both sides at once
    // is avoided too: host drives nothing until a direction is chosen
    assign drv_l = (state_ff == otx_pkg::OTX_ON || state_ff == otx_pkg::OTX_SET_DIR)
                   && flow_ff == `OTX_FLOW_L2R;
    assign drv_r = (state_ff == otx_pkg::OTX_ON || state_ff == otx_pkg::OTX_SET_DIR)
                   && flow_ff == `OTX_FLOW_R2L;

    assign req_ready      = (state_ff == otx_pkg::OTX_OFF) || (state_ff == otx_pkg::OTX_ON);
    assign flow_select    = flow_ff;
    assign drive_enable_n = en_n_ff;
    assign link_on        = (state_ff == otx_pkg::OTX_ON);
    assign rx_data        = rx_ff;

    // one shared control pair feeds every lane
    genvar g;
    generate
        for (g = 0; g < `OTX_WIDTH; g++) begin : g_lane
            otx_lane u_lane (
                .drv_left   (drv_l),
                .drv_right  (drv_r),
                .left_val   (tx_ff[g]),
                .right_val  (tx_ff[g]),
                .left_in    (left_port_bit_in[g]),
                .right_in   (right_port_bit_in[g]),
                .left_out   (left_port_bit_out[g]),
                .left_oe_n  (left_port_bit_oe_n[g]),
                .right_out  (right_port_bit_out[g]),
                .right_oe_n (right_port_bit_oe_n[g]),
                .left_seen  (l_seen[g]),
                .right_seen (r_seen[g])
            );
        end
    endgenerate

    always_comb begin
        nxt_state = state_ff;
        nxt_flow  = flow_ff;
        nxt_en_n  = en_n_ff;
        nxt_want  = want_ff;
        nxt_cnt   = cnt_ff;
        nxt_tx    = tx_data;
        // capture what the device drives onto the far side
        nxt_rx    = (flow_ff == `OTX_FLOW_L2R) ? r_seen : l_seen;
        unique case (state_ff)
            otx_pkg::OTX_OFF: begin
                nxt_en_n = `OTX_EN_OFF;
                if (req_valid && !req_off) begin
                    nxt_flow  = req_flow;
                    nxt_state = otx_pkg::OTX_SET_DIR;
                end
            end
            otx_pkg::OTX_SET_DIR: begin
                // direction settles one cycle before enabling
                nxt_en_n  = `OTX_EN_ON;
                nxt_state = otx_pkg::OTX_ON;
            end
            otx_pkg::OTX_ON: begin
                if (req_valid && (req_off || req_flow != flow_ff)) begin
                    // turn off before reversing so the two never fight
                    nxt_en_n  = `OTX_EN_OFF;
                    nxt_want  = !req_off;
                    nxt_flow  = flow_ff;
                    nxt_cnt   = `OTX_CNT_W'(`OTX_GAP_CYC);
                    nxt_state = otx_pkg::OTX_GAP;
                    if (!req_off) begin
                        nxt_flow = req_flow;
                    end
                end
            end
            otx_pkg::OTX_GAP: begin
                nxt_cnt = cnt_ff - `OTX_CNT_W'(1);
                if (cnt_ff == `OTX_CNT_W'(1)) begin
                    nxt_state = want_ff ? otx_pkg::OTX_SET_DIR : otx_pkg::OTX_OFF;
                end
            end
            default: begin
                nxt_state = otx_pkg::OTX_OFF;
                nxt_en_n  = `OTX_EN_OFF;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_ff <= otx_pkg::OTX_OFF;
            flow_ff  <= `OTX_FLOW_R2L;
            en_n_ff  <= `OTX_EN_OFF;
            want_ff  <= 1'b0;
            cnt_ff   <= '0;
            tx_ff    <= '0;
            rx_ff    <= '0;
        end else begin
            state_ff <= nxt_state;
            flow_ff  <= nxt_flow;
            en_n_ff  <= nxt_en_n;
            want_ff  <= nxt_want;
            cnt_ff   <= nxt_cnt;
            tx_ff    <= nxt_tx;
            rx_ff    <= nxt_rx;
        end
    end

    property p_no_fight;
        @(posedge clk) disable iff (!rst_b)
        !en_n_ff |-> ((flow_ff == `OTX_FLOW_L2R) ? &right_port_bit_oe_n
                                                  : &left_port_bit_oe_n);
    endproperty
    a_no_fight: assert property (p_no_fight) else $error("host drives device side");

    property p_off_floats;
        @(posedge clk) disable iff (!rst_b)
        state_ff == otx_pkg::OTX_OFF |-> drive_enable_n;
    endproperty
    a_off_floats: assert property (p_off_floats) else $error("enable low while off");

    sequence s_flip;
        !drive_enable_n ##1 $changed(flow_select);
    endsequence
    property p_flip_disabled;
        @(posedge clk) disable iff (!rst_b)
        s_flip |-> drive_enable_n;
    endproperty
    a_flip_disabled: assert property (p_flip_disabled) else $error("direction flipped while on");

    property p_enable_path;
        @(posedge clk) disable iff (!rst_b)
        $fell(drive_enable_n) |-> $past(state_ff) == otx_pkg::OTX_SET_DIR;
    endproperty
    a_enable_path: assert property (p_enable_path) else $error("enable without setup");

    property p_gap_len;
        @(posedge clk) disable iff (!rst_b)
        $rose(drive_enable_n) && state_ff == otx_pkg::OTX_GAP
            |-> drive_enable_n [*4];
    endproperty
    a_gap_len: assert property (p_gap_len) else $error("turnaround gap too short");

    // reversal: both sides released for the whole five-cycle gap, then setup, then enable
    sequence s_rev_req;
        state_ff == otx_pkg::OTX_ON && req_valid && !req_off && (req_flow != flow_ff);
    endsequence
    sequence s_rev_walk;
        (drive_enable_n && (&left_port_bit_oe_n) && (&right_port_bit_oe_n)) [*5]
            ##1 (state_ff == otx_pkg::OTX_SET_DIR && drive_enable_n)
            ##1 !drive_enable_n;
    endsequence
    property p_rev_walk;
        @(posedge clk) disable iff (!rst_b)
        s_rev_req |=> s_rev_walk;
    endproperty
    a_rev_walk: assert property (p_rev_walk) else $error("reversal walk broken");

    // switch-off keeps the device released through the gap and stays off
    sequence s_off_req;
        state_ff == otx_pkg::OTX_ON && req_valid && req_off;
    endsequence
    sequence s_off_walk;
        drive_enable_n [*5] ##1 (state_ff == otx_pkg::OTX_OFF && drive_enable_n);
    endsequence
    property p_off_walk;
        @(posedge clk) disable iff (!rst_b)
        s_off_req |=> s_off_walk;
    endproperty
    a_off_walk: assert property (p_off_walk) else $error("switch-off walk broken");

    // direction pin is settled a full cycle before the enable drops
    sequence s_start_req;
        state_ff == otx_pkg::OTX_OFF && req_valid && !req_off;
    endsequence
    property p_start_walk;
        @(posedge clk) disable iff (!rst_b)
        s_start_req |=> (drive_enable_n && flow_select == $past(req_flow)) ##1 !drive_enable_n;
    endproperty
    a_start_walk: assert property (p_start_walk) else $error("start-up walk broken");

    // host may only drive the side that the device reads
    property p_host_side;
        @(posedge clk) disable iff (!rst_b)
        ((&left_port_bit_oe_n) || flow_select == `OTX_FLOW_L2R)
            && ((&right_port_bit_oe_n) || flow_select == `OTX_FLOW_R2L);
    endproperty
    a_host_side: assert property (p_host_side) else $error("host drives device output side");

    // all lanes share one control, so no lane may differ from its neighbours
    property p_lanes_match;
        @(posedge clk) disable iff (!rst_b)
        (&left_port_bit_oe_n || ~|left_port_bit_oe_n)
            && (&right_port_bit_oe_n || ~|right_port_bit_oe_n);
    endproperty
    a_lanes_match: assert property (p_lanes_match) else $error("lanes driven unevenly");

    // leaving reset everything is released, device outputs floating
    property p_reset_quiet;
        @(posedge clk)
        $rose(rst_b) |-> drive_enable_n && (&left_port_bit_oe_n) && (&right_port_bit_oe_n);
    endproperty
    a_reset_quiet: assert property (p_reset_quiet) else $error("not quiet after reset");
endmodule

/* verif/otx_dev_model.sv */
`timescale 1ns/1ps
`include "otx_cfg.svh"
// far-side transceiver: purely combinational, floating nodes show inverse of host value
module otx_dev_model (
    input  wire logic                  flow_select,
    input  wire logic                  drive_enable_n,
    input  wire logic [`OTX_WIDTH-1:0] l_out,
    input  wire logic [`OTX_WIDTH-1:0] l_oe_n,
    input  wire logic [`OTX_WIDTH-1:0] r_out,
    input  wire logic [`OTX_WIDTH-1:0] r_oe_n,
    output logic [`OTX_WIDTH-1:0]      l_wire,
    output logic [`OTX_WIDTH-1:0]      r_wire,
    output logic                       clash
);
    logic dl;
    logic dr;
    assign dl = !drive_enable_n && !flow_select;
    assign dr = !drive_enable_n && flow_select;
    always_comb begin
        clash = 1'b0;
        for (int i = 0; i < `OTX_WIDTH; i++) begin
            l_wire[i] = !l_oe_n[i] ? l_out[i] : (dl ? (!r_oe_n[i] ? r_out[i] : ~r_out[i]) : ~l_out[i]);
            r_wire[i] = !r_oe_n[i] ? r_out[i] : (dr ? (!l_oe_n[i] ? l_out[i] : ~l_out[i]) : ~r_out[i]);
            clash = clash | (!l_oe_n[i] && dl) | (!r_oe_n[i] && dr);
        end
    end
endmodule

/* verif/tb.sv */
`timescale 1ns/1ps
`include "otx_cfg.svh"
module tb;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic req_valid = 1'b0;
    logic req_flow = 1'b0;
    logic req_off = 1'b0;
    logic [`OTX_WIDTH-1:0] tx_data = 8'h00;
    logic req_ready, link_on, flow_select, drive_enable_n, clash;
    logic [`OTX_WIDTH-1:0] rx_data, lw, rw, lo, loe, ro, roe;
    int err_count = 0;
    int checks_done = 0;
    always #2 clk = ~clk;
    otx_host DUT (.clk(clk), .rst_b(rst_b), .req_valid(req_valid), .req_flow(req_flow),
        .req_off(req_off), .req_ready(req_ready), .tx_data(tx_data), .rx_data(rx_data),
        .link_on(link_on), .flow_select(flow_select), .drive_enable_n(drive_enable_n),
        .left_port_bit_in(lw), .left_port_bit_out(lo), .left_port_bit_oe_n(loe),
        .right_port_bit_in(rw), .right_port_bit_out(ro), .right_port_bit_oe_n(roe));
    otx_dev_model u_dev (.flow_select(flow_select), .drive_enable_n(drive_enable_n),
        .l_out(lo), .l_oe_n(loe), .r_out(ro), .r_oe_n(roe), .l_wire(lw), .r_wire(rw),
        .clash(clash));
    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask
    always @(negedge clk) if (rst_b && clash !== 1'b0) chk("clash", 8'h00, 8'h01);
    task automatic req(input logic f, input logic off, output int waited);
        int n;
        @(posedge clk);
        req_valid <= 1'b1;
        req_flow <= f;
        req_off <= off;
        #1;
        n = 0;
        while (req_ready !== 1'b1 && n < 50) begin @(posedge clk); #1; n++; end
        if (n >= 50) chk("ready_wait", 8'h01, 8'h00);
        @(posedge clk);
        req_valid <= 1'b0;
        n = 0;
        #1;
        while ((req_ready !== 1'b1 || link_on !== !off) && n < 50) begin @(posedge clk); #1; n++; end
        if (n >= 50) chk("answer_wait", 8'h01, 8'h00);
        waited = n;
    endtask
    task automatic t_reset;
        chk("enable_n", 8'h01, {7'h0, drive_enable_n});
        chk("left_oe_n", 8'hff, loe);
        chk("right_oe_n", 8'hff, roe);
        chk("req_ready", 8'h01, {7'h0, req_ready});
        $display("test reset done");
    endtask
    task automatic t_flow(input logic f, input logic [7:0] d);
        int w;
        req(f, 1'b0, w);
        @(posedge clk);
        tx_data <= d;
        repeat (3) @(posedge clk);
        #1;
        chk("flow_select", {7'h0, f}, {7'h0, flow_select});
        chk("enable_n", 8'h00, {7'h0, drive_enable_n});
        chk("host_oe_n", 8'h00, f ? loe : roe);
        chk("far_oe_n", 8'hff, f ? roe : loe);
        chk("far_wire", d, f ? rw : lw);
        chk("rx_data", d, rx_data);
        $display("test flow %0d data %h done", f, d);
    endtask
    task automatic t_off;
        int w;
        req(1'b0, 1'b1, w);
        chk("gap_cycles", 8'(`OTX_GAP_CYC), w[7:0]);
        chk("enable_n", 8'h01, {7'h0, drive_enable_n});
        chk("link_on", 8'h00, {7'h0, link_on});
        chk("left_oe_n", 8'hff, loe);
        chk("right_oe_n", 8'hff, roe);
        $display("test off done");
    endtask
    task automatic t_midreset;
        @(posedge clk);
        rst_b <= 1'b0;
        @(posedge clk);
        #1;
        chk("enable_n", 8'h01, {7'h0, drive_enable_n});
        chk("left_oe_n", 8'hff, loe);
        chk("right_oe_n", 8'hff, roe);
        chk("link_on", 8'h00, {7'h0, link_on});
        @(posedge clk);
        rst_b <= 1'b1;
        $display("test mid-run reset done");
    endtask
    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    initial begin
        #8000;
        err_count++;
        report_and_stop();
    end
    initial begin
        repeat (2) @(posedge clk);
        #1;
        t_reset();
        @(posedge clk);
        rst_b <= 1'b1;
        t_flow(1'b1, 8'h5a);
        t_flow(1'b0, 8'ha5);
        t_flow(1'b0, 8'h3c);
        t_flow(1'b1, 8'hff);
        t_midreset();
        t_flow(1'b1, 8'hc3);
        t_off();
        report_and_stop();
    end
endmodule
